// file: shared/fsm_pkg.sv
// constants and types for the fault severity monitor
package fsm_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned STALL_US = 100;
  localparam int unsigned STARTUP_US = 100;
  localparam int unsigned STANDBY_MS = 15;
  localparam int unsigned SHUTDOWN_MS = 20;
  // stall is "more than" the time: count floors to whole cycles, flag on the next
  localparam int unsigned STALL_CYC = STALL_US * (CLK_HZ / 1_000_000);
  localparam int unsigned STARTUP_CYC = STARTUP_US * (CLK_HZ / 1_000_000);
  localparam int unsigned STANDBY_CYC = STANDBY_MS * (CLK_HZ / 1_000);
  localparam int unsigned SHUTDOWN_CYC = SHUTDOWN_MS * (CLK_HZ / 1_000);
  localparam int CNT_W = 20;
  localparam int TMR_W = 12;
  // severity codes on the level output
  localparam logic [2:0] SEV_NONE = 3'h0;
  localparam logic [2:0] SEV_AUX = 3'h1;
  localparam logic [2:0] SEV_REG = 3'h2;
  localparam logic [2:0] SEV_OVV = 3'h3;
  localparam logic [2:0] SEV_HOT = 3'h4;
  localparam logic [2:0] SEV_OVC = 3'h5;
  localparam logic [2:0] SEV_RST = SEV_NONE;
  typedef enum logic [1:0] {ST_STARTUP, ST_RUN, ST_STANDBY, ST_SHUTDOWN} fsm_state_t;
endpackage

// file: design/fsm_sync3.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module fsm_sync3 (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic d_i,
  output logic q_o
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      q_o <= 1'b0;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // a change counts once the last two stages agree
      if (s2_reg == s3_reg) begin
        q_o <= s3_reg;
      end
    end
  end
endmodule

// file: design/fsm_monitor.sv
// fault and warning monitor with severity-coded level output
`timescale 1ns/1ps
// Notes on behaviour
// - die above 125C warns, converter keeps running
// - die above 150C disables switch output
// - resume switching once cooled to 125C
// - open-drain fault flag pulls low on any condition
// - level output normally top, steps down on fault
// - severity codes 1..5 map to five levels
// - aux undervoltage severity 1, main severity 2
// - shaping node out of range is severity 2
// - switch node stuck over 100us is severity 2
// - switch overvoltage severity 3, hot die 4
// - sense or switch overcurrent is severity 5
// - highest active severity is shown outside start-up
// - start-up at power-on and after 15ms standby
// - start-up shows overcurrent then out-of-regulation
// - clamp holding dimming low 20ms shuts down
// - standby drops level output to ground
module fsm_monitor
  import fsm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic aux_supply_low_i,
  input wire logic main_supply_low_i,
  input wire logic shaping_node_bad_i,
  input wire logic switch_node_i,
  input wire logic switch_node_ovv_i,
  input wire logic die_above_125_i,
  input wire logic die_above_150_i,
  input wire logic sense_voltage_high_i,
  input wire logic switch_current_high_i,
  input wire logic dim_i,
  input wire logic overvoltage_clamp_i,
  output logic fault_flag_o,
  output logic fault_flag_oe_o,
  output logic [2:0] severity_o,
  output logic level_off_o,
  output logic switch_enable_o,
  output logic startup_o
);
  localparam int NIN = 11;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] syn;
  assign raw_in = {overvoltage_clamp_i, dim_i, switch_current_high_i, sense_voltage_high_i,
                   die_above_150_i, die_above_125_i, switch_node_ovv_i, switch_node_i,
                   shaping_node_bad_i, main_supply_low_i, aux_supply_low_i};
  for (genvar g = 0; g < NIN; g++) begin : g_sync
    fsm_sync3 u_sync (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .d_i(raw_in[g]),
      .q_o(syn[g])
    );
  end
  logic aux_low, main_low, shp_bad, sw_node, sw_ovv, hot125, hot150, sns_hi, ilx_hi;
  logic dim, clamp;
  assign aux_low = syn[0];
  assign main_low = syn[1];
  assign shp_bad = syn[2];
  assign sw_node = syn[3];
  assign sw_ovv = syn[4];
  assign hot125 = syn[5];
  assign hot150 = syn[6];
  assign sns_hi = syn[7];
  assign ilx_hi = syn[8];
  assign dim = syn[9];
  assign clamp = syn[10];

  function automatic logic [CNT_W-1:0] inc_sat(input logic [CNT_W-1:0] v);
    inc_sat = (v == {CNT_W{1'b1}}) ? v : v + 1'b1;
  endfunction

  fsm_state_t state_reg;
  logic [CNT_W-1:0] low_cnt_reg;
  logic [TMR_W-1:0] stall_cnt_reg;
  logic [TMR_W-1:0] start_cnt_reg;
  logic sw_node_last_reg;
  logic stalled_reg;
  logic thermal_off_reg;
  logic [CNT_W-1:0] low_cnt_next;
  assign low_cnt_next = dim ? '0 : inc_sat(low_cnt_reg);

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      low_cnt_reg <= '0;
    end else begin
      low_cnt_reg <= low_cnt_next;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= ST_STARTUP;
      start_cnt_reg <= '0;
    end else begin
      case (state_reg)
        ST_STARTUP: begin
          start_cnt_reg <= start_cnt_reg + 1'b1;
          if (start_cnt_reg == TMR_W'(STARTUP_CYC - 1)) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          start_cnt_reg <= '0;
          if (clamp && !dim && low_cnt_reg >= CNT_W'(SHUTDOWN_CYC)) begin
            state_reg <= ST_SHUTDOWN;
          end else if (low_cnt_reg >= CNT_W'(STANDBY_CYC)) begin
            state_reg <= ST_STANDBY;
          end
        end
        ST_STANDBY: begin
          if (clamp && !dim && low_cnt_reg >= CNT_W'(SHUTDOWN_CYC)) begin
            state_reg <= ST_SHUTDOWN;
          end else if (dim) begin
            state_reg <= ST_STARTUP;
          end
        end
        ST_SHUTDOWN: begin
          // only a reset leaves shutdown
          state_reg <= ST_SHUTDOWN;
        end
        default: begin
          state_reg <= ST_STARTUP;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sw_node_last_reg <= 1'b0;
      stall_cnt_reg <= '0;
      stalled_reg <= 1'b0;
    end else begin
      sw_node_last_reg <= sw_node;
      // gated dimming holds the node on purpose, so no stall then
      if (sw_node != sw_node_last_reg || state_reg != ST_RUN || !dim) begin
        stall_cnt_reg <= '0;
        stalled_reg <= 1'b0;
      end else if (stall_cnt_reg >= TMR_W'(STALL_CYC)) begin
        stalled_reg <= 1'b1;
      end else begin
        stall_cnt_reg <= stall_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      thermal_off_reg <= 1'b0;
    end else if (hot150) begin
      thermal_off_reg <= 1'b1;
    end else if (!hot125) begin
      thermal_off_reg <= 1'b0;
    end
  end

  logic [2:0] sev_now;
  logic in_startup;
  assign in_startup = (state_reg == ST_STARTUP);
  always_comb begin
    // no condition keeps the top level
    sev_now = SEV_NONE;
    if (aux_low) sev_now = SEV_AUX;
    if (main_low || shp_bad || stalled_reg) sev_now = SEV_REG;
    if (sw_ovv) sev_now = SEV_OVV;
    if (hot125 || thermal_off_reg) sev_now = SEV_HOT;
    if (sns_hi || ilx_hi) sev_now = SEV_OVC;
    // inductor charging shows overcurrent, then regulation loss
    if (in_startup) begin
      sev_now = (start_cnt_reg < TMR_W'(STARTUP_CYC / 2)) ? SEV_OVC : SEV_REG;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      severity_o <= SEV_RST;
      fault_flag_oe_o <= 1'b0;
      fault_flag_o <= 1'b0;
      level_off_o <= 1'b0;
      switch_enable_o <= 1'b0;
      startup_o <= 1'b0;
    end else begin
      severity_o <= sev_now;
      // open drain flag, severity one included
      fault_flag_oe_o <= (sev_now != SEV_NONE);
      fault_flag_o <= 1'b0;
      level_off_o <= (state_reg == ST_STANDBY) || (state_reg == ST_SHUTDOWN);
      switch_enable_o <= (state_reg == ST_RUN || in_startup) && dim && !thermal_off_reg;
      startup_o <= in_startup;
    end
  end

  // shadow count of the start-up window, kept apart from the sequencer
  localparam logic [TMR_W-1:0] START_LAST = TMR_W'(STARTUP_CYC - 1);
  localparam logic [TMR_W-1:0] START_HALF = TMR_W'(STARTUP_CYC / 2);
  logic [TMR_W-1:0] start_len_reg;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      start_len_reg <= '0;
    end else if (in_startup) begin
      start_len_reg <= start_len_reg + 1'b1;
    end else begin
      start_len_reg <= '0;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  flag_tracks_sev_a: assert property (fault_flag_oe_o == (severity_o != SEV_NONE))
    else $error("fault flag disagrees with severity");
  ovc_wins_a: assert property ((sev_now == SEV_OVC) |=> severity_o == SEV_OVC)
    else $error("overcurrent not shown");
  priority_a: assert property ((!in_startup && sns_hi && sw_ovv) |=> severity_o == SEV_OVC)
    else $error("lower severity shown");
  hot_off_a: assert property (hot150 |=> ##1 !switch_enable_o)
    else $error("switch on while over 150C");
  hyst_a: assert property ((thermal_off_reg && hot125 && !hot150) |=> thermal_off_reg)
    else $error("resumed above 125C");
  hot_warn_a: assert property ((!in_startup && hot125 && !sns_hi && !ilx_hi) |=> severity_o == SEV_HOT)
    else $error("no temperature warning");
  aux_sev_a: assert property ((!in_startup && aux_low && !main_low && !shp_bad && !stalled_reg
      && !sw_ovv && !hot125 && !thermal_off_reg && !sns_hi && !ilx_hi) |=> severity_o == SEV_AUX)
    else $error("aux undervoltage code wrong");
  startup_len_a: assert property ($rose(state_reg == ST_STARTUP) |-> in_startup [*8])
    else $error("start-up too short");
  stall_a: assert property ((state_reg == ST_RUN && dim && $stable(sw_node)
      && stall_cnt_reg == TMR_W'(STALL_CYC)) |=> stalled_reg)
    else $error("stall not flagged");
  standby_a: assert property ((state_reg == ST_STANDBY) |=> level_off_o)
    else $error("level not grounded in standby");
  release_a: assert property ((sev_now == SEV_NONE) |=> !fault_flag_oe_o)
    else $error("flag held after conditions cleared");
  start_hold_a: assert property (in_startup && start_len_reg < START_LAST |=> in_startup)
    else $error("start-up window cut short");
  start_end_a: assert property (in_startup && start_len_reg == START_LAST |=> !in_startup)
    else $error("start-up window overran");
  start_ovc_a: assert property (in_startup && start_len_reg < START_HALF
      |=> severity_o == SEV_OVC)
    else $error("start-up overcurrent phase missing");
  start_reg_a: assert property (in_startup && start_len_reg >= START_HALF
      |=> severity_o == SEV_REG && fault_flag_oe_o)
    else $error("start-up regulation phase missing");
  start_mark_a: assert property (in_startup |=> startup_o && fault_flag_oe_o)
    else $error("start-up window not marked");
  main_low_a: assert property (!in_startup && main_low && !sw_ovv && !hot125
      && !thermal_off_reg && !sns_hi && !ilx_hi |=> severity_o == SEV_REG)
    else $error("main undervoltage code wrong");
  shaping_a: assert property (!in_startup && shp_bad && !sw_ovv && !hot125
      && !thermal_off_reg && !sns_hi && !ilx_hi |=> severity_o == SEV_REG && fault_flag_oe_o)
    else $error("regulation loss code wrong");
  ovv_sev_a: assert property (!in_startup && sw_ovv && !hot125 && !thermal_off_reg
      && !sns_hi && !ilx_hi |=> severity_o == SEV_OVV)
    else $error("switch overvoltage code wrong");
  ilx_sev_a: assert property (!in_startup && ilx_hi |=> severity_o == SEV_OVC)
    else $error("switch overcurrent code wrong");
  hot_run_a: assert property (state_reg == ST_RUN && dim && !thermal_off_reg
      |=> switch_enable_o)
    else $error("switching stopped below shutdown point");
  cool_resume_a: assert property (thermal_off_reg && !hot125
      && !hot150 |=> !thermal_off_reg)
    else $error("no resume after cooling");
  off_still_a: assert property (thermal_off_reg |=> !switch_enable_o)
    else $error("switch on during thermal shutdown");
  shut_sticky_a: assert property (state_reg == ST_SHUTDOWN |=> state_reg == ST_SHUTDOWN)
    else $error("shutdown left without reset");
  shut_level_a: assert property (state_reg == ST_SHUTDOWN |=> level_off_o)
    else $error("level not grounded in shutdown");
  wake_a: assert property (state_reg == ST_STANDBY && dim |=> state_reg == ST_STARTUP)
    else $error("no start-up after standby");
  stall_clear_a: assert property (stalled_reg
      && sw_node != sw_node_last_reg |=> !stalled_reg)
    else $error("stall held after node moved");
  run_level_a: assert property (state_reg == ST_RUN |=> !level_off_o)
    else $error("level grounded while running");
  sev_range_a: assert property (severity_o <= SEV_OVC)
    else $error("severity code out of range");
  quiet_a: assert property (!in_startup && !aux_low && !main_low && !shp_bad
      && !stalled_reg && !sw_ovv && !hot125 && !thermal_off_reg && !sns_hi && !ilx_hi
      |=> severity_o == SEV_NONE)
    else $error("level not back to normal");
  c_standby: cover property (state_reg == ST_STANDBY ##[1:20] state_reg == ST_STARTUP);
  c_shutdown: cover property (state_reg == ST_SHUTDOWN);
  c_stall: cover property ($rose(stalled_reg));
  c_thermal: cover property ($fell(thermal_off_reg));
  c_split: cover property (in_startup && severity_o == SEV_OVC ##1 severity_o == SEV_REG);
endmodule

// file: test/fsm_host_model.sv
// host controller and converter-side model facing the fault monitor
`timescale 1ns/1ps
module fsm_host_model
  import fsm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic toggle_i,
  input wire logic gate_i,
  input wire logic startup_i,
  input wire logic [2:0] severity_i,
  output logic switch_node_o,
  output logic dim_o,
  output logic diag_valid_o
);
  logic [3:0] div_reg = 4'h0;
  initial switch_node_o = 1'b0;
  // switch node keeps moving while the converter regulates
  always @(posedge mclk_i) begin
    div_reg <= div_reg + 4'h1;
    if (toggle_i && div_reg == 4'hF) begin
      switch_node_o <= !switch_node_o;
    end
  end
  assign diag_valid_o = !startup_i;
  assign dim_o = !(gate_i && diag_valid_o && severity_i == SEV_OVV);
endmodule

// file: test/fsm_monitor_tb.sv
// self-checking bench for the fault severity monitor
`timescale 1ns/1ps
module fsm_monitor_tb;
  import fsm_pkg::*;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] cond = 8'h00;
  logic tog = 1'b1;
  logic gate = 1'b0;
  logic clamp = 1'b0;
  logic sw, dim, flag, flag_oe, lvl_off, sw_en, start, valid;
  logic [2:0] sev;
  int n_fail = 0;
  int n_compared = 0;
  int i;
  // flag line has a pull-up, so released means high
  wire flag_wire = flag_oe ? flag : 1'b1;
  initial forever #25 mclk_i = !mclk_i;
  fsm_monitor fsm_monitor_i (.mclk_i(mclk_i), .rstn_i(rstn_i), .aux_supply_low_i(cond[0]),
    .main_supply_low_i(cond[1]), .shaping_node_bad_i(cond[2]), .switch_node_i(sw),
    .switch_node_ovv_i(cond[3]), .die_above_125_i(cond[4]), .die_above_150_i(cond[5]),
    .sense_voltage_high_i(cond[6]), .switch_current_high_i(cond[7]), .dim_i(dim),
    .overvoltage_clamp_i(clamp), .fault_flag_o(flag), .fault_flag_oe_o(flag_oe),
    .severity_o(sev), .level_off_o(lvl_off), .switch_enable_o(sw_en), .startup_o(start));
  fsm_host_model fsm_host_model_i (.mclk_i(mclk_i), .toggle_i(tog), .gate_i(gate),
    .startup_i(start), .severity_i(sev), .switch_node_o(sw), .dim_o(dim),
    .diag_valid_o(valid));
  task automatic end_of_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk_sev(input logic [2:0] exp);
    n_compared++;
    if (sev !== exp) begin
      n_fail++;
      $display("ERROR t=%0t severity got %h exp %h", $time, sev, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t bit got %h exp %h", $time, got, exp);
    end
  endtask
  // inputs pass a synchroniser and filter, so allow the full latency
  task automatic apply(input logic [7:0] c);
    @(posedge mclk_i);
    cond <= c;
    repeat (8) @(posedge mclk_i);
    #1;
  endtask
  function automatic logic [2:0] sev_of(input int k);
    case (k)
      0: return SEV_AUX;
      1, 2: return SEV_REG;
      3: return SEV_OVV;
      4: return SEV_HOT;
      default: return SEV_OVC;
    endcase
  endfunction
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_fail++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge mclk_i);
    chk_sev(SEV_RST);
    chk_bit(flag_wire, 1'b1);
    rstn_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    #1;
    chk_bit(start, 1'b1);
    chk_sev(SEV_OVC);
    chk_bit(flag_wire, 1'b0);
    repeat (1200) @(posedge mclk_i);
    #1;
    chk_sev(SEV_REG);
    for (i = 0; i < 3000 && start !== 1'b0; i++) @(posedge mclk_i);
    if (start !== 1'b0) begin
      n_fail++;
      end_of_test();
    end
    apply(8'h00);
    chk_sev(SEV_NONE);
    chk_bit(flag_wire, 1'b1);
    chk_bit(lvl_off, 1'b0);
    for (i = 0; i < 8; i++) begin
      if (i != 5) begin
        apply(8'h01 << i);
        chk_sev(sev_of(i));
        chk_bit(flag_wire, 1'b0);
        chk_bit(sw_en, 1'b1);
        apply(8'h00);
        chk_sev(SEV_NONE);
        chk_bit(flag_wire, 1'b1);
      end
    end
    apply(8'h44);
    chk_sev(SEV_OVC);
    apply(8'h48);
    chk_sev(SEV_OVC);
    apply(8'h1B);
    chk_sev(SEV_HOT);
    apply(8'h0B);
    chk_sev(SEV_OVV);
    apply(8'h30);
    chk_bit(sw_en, 1'b0);
    apply(8'h10);
    chk_bit(sw_en, 1'b0);
    chk_sev(SEV_HOT);
    apply(8'h00);
    chk_bit(sw_en, 1'b1);
    tog <= 1'b0;
    repeat (STALL_CYC - 50) @(posedge mclk_i);
    #1;
    chk_sev(SEV_NONE);
    repeat (120) @(posedge mclk_i);
    #1;
    chk_sev(SEV_REG);
    chk_bit(flag_wire, 1'b0);
    tog <= 1'b1;
    repeat (40) @(posedge mclk_i);
    #1;
    chk_sev(SEV_NONE);
    gate <= 1'b1;
    clamp <= 1'b1;
    apply(8'h08);
    // gated dimming needs its own pass through the synchroniser
    repeat (4) @(posedge mclk_i);
    #1;
    chk_bit(dim, 1'b0);
    chk_bit(sw_en, 1'b0);
    chk_sev(SEV_OVV);
    chk_bit(lvl_off, 1'b0);
    apply(8'h00);
    repeat (4) @(posedge mclk_i);
    #1;
    chk_bit(dim, 1'b1);
    chk_bit(sw_en, 1'b1);
    gate <= 1'b0;
    clamp <= 1'b0;
    end_of_test();
  end
endmodule
